// >>> rtl/cle_exec_unit.sv
// execution unit for indirect call, control-register loads and loop-last load
module cle_exec_unit (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic instr_is_branch,
  input wire logic ext_slot,
  input wire logic [31:0] ext_slot_dest,
  output logic [3:0] gpr_rd_idx,
  input wire logic [31:0] gpr_rd_data,
  output logic gpr_wr_en,
  output logic [3:0] gpr_wr_idx,
  output logic [31:0] gpr_wr_data,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic pc_load,
  output logic [31:0] pc_target,
  output logic pc_step,
  output logic illegal_slot,
  output logic irq_block,
  output logic addr_err_block,
  output logic t_flag,
  output logic [31:0] status_reg,
  output logic [31:0] global_base_register,
  output logic [31:0] vector_base_register,
  output logic [31:0] circular_addressing_register,
  output logic [31:0] loop_last_pointer,
  output logic [31:0] loop_begin_pointer,
  output logic [31:0] return_link_holder,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  function automatic logic cle_match(input logic [15:0] w, input logic [15:0] pat, input logic [15:0] msk);
    cle_match = (w & msk) == pat;
  endfunction

  // maps bits 7:4 of a control-load form onto a destination
  function automatic cle_pkg::cle_creg_t cle_sel(input logic [3:0] f);
    case (f)
      cle_pkg::SEL_STATUS: cle_sel = cle_pkg::CR_STATUS;
      cle_pkg::SEL_GBR: cle_sel = cle_pkg::CR_GBR;
      cle_pkg::SEL_VBR: cle_sel = cle_pkg::CR_VBR;
      cle_pkg::SEL_MOD: cle_sel = cle_pkg::CR_MOD;
      cle_pkg::SEL_RE: cle_sel = cle_pkg::CR_RE;
      cle_pkg::SEL_RS: cle_sel = cle_pkg::CR_RS;
      default: cle_sel = cle_pkg::CR_NONE;
    endcase
  endfunction

  cle_pkg::cle_state_t state_r;
  cle_pkg::cle_state_t state_nxt;
  logic ctrl_en_r;
  logic [cle_pkg::EVT_W-1:0] evt_r;
  logic [cle_pkg::EVT_W-1:0] mask_r;
  logic slot_pend_r;
  logic pop_in_slot_r;
  logic int_hold_r;
  logic [31:0] call_tgt_r;
  logic [31:0] link_nxt_r;
  logic [31:0] pop_addr_r;
  logic [31:0] pop_data_r;
  logic [3:0] pop_idx_r;
  cle_pkg::cle_creg_t pop_dst_r;
  logic [31:0] status_r;
  logic [31:0] gbr_r;
  logic [31:0] vbr_r;
  logic [31:0] mod_r;
  logic [31:0] re_r;
  logic [31:0] rs_r;
  logic [31:0] pr_r;
  logic pc_load_r;
  logic [31:0] pc_target_r;
  logic pc_step_r;
  logic illegal_r;
  logic gpr_wr_en_r;
  logic [3:0] gpr_wr_idx_r;
  logic [31:0] gpr_wr_data_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // decode of the issued word
  wire accept = instr_valid && instr_ready;
  wire is_call = cle_match(instr_word, cle_pkg::CALL_PAT, cle_pkg::CALL_MASK);
  wire is_sll = cle_match(instr_word, cle_pkg::SLL_PAT, cle_pkg::SLL_MASK);
  wire grp4 = instr_word[15:12] == cle_pkg::GRP_HI;
  wire cle_pkg::cle_creg_t dst = cle_sel(instr_word[7:4]);
  wire is_ldc = grp4 && (instr_word[3:0] == cle_pkg::LDC_LO) && (dst != cle_pkg::CR_NONE);
  wire is_pop = grp4 && (instr_word[3:0] == cle_pkg::POP_LO) && (dst != cle_pkg::CR_NONE);
  wire slot_now = accept && slot_pend_r;
  wire slot_bad = slot_now && (instr_is_branch || is_call);
  wire run = accept && !slot_bad;

  // displacement: sign-extend, double, add to base
  wire [31:0] disp = {{23{instr_word[7]}}, instr_word[7:0], 1'b0};
  wire [31:0] sll_base = slot_pend_r ? (call_tgt_r + cle_pkg::SLOT_OFS)
                       : ext_slot ? (ext_slot_dest + cle_pkg::SLOT_OFS)
                       : (instr_pc + cle_pkg::PC_OFS);
  wire [31:0] sll_addr = sll_base + disp;

  // control register write port, shared by the three load forms
  wire pop_done = state_r == cle_pkg::ST_POP_WB;
  wire ldc_go = run && is_ldc;
  wire sll_go = run && is_sll;
  wire creg_we = ldc_go || sll_go || pop_done;
  wire cle_pkg::cle_creg_t creg_sel = pop_done ? pop_dst_r : sll_go ? cle_pkg::CR_RE : dst;
  wire [31:0] pop_val = (pop_dst_r == cle_pkg::CR_STATUS) ? (pop_data_r & cle_pkg::STATUS_MASK) : pop_data_r;
  wire [31:0] creg_data = pop_done ? pop_val : sll_go ? sll_addr : gpr_rd_data;

  // slot ends at completion; a multi-cycle slot finishes in the write-back cycle
  wire slot_end = (slot_now && !slot_bad && !is_pop) || (pop_done && pop_in_slot_r);
  wire step_go = (run && !is_call && !is_pop && !slot_pend_r) || (pop_done && !pop_in_slot_r);

  assign instr_ready = ctrl_en_r && (state_r == cle_pkg::ST_IDLE);
  assign gpr_rd_idx = instr_word[11:8];

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      cle_pkg::ST_IDLE:
      begin
        if (run && is_call)
          state_nxt = cle_pkg::ST_CALL2;
        else if (run && is_pop)
          state_nxt = cle_pkg::ST_POP_RD;
      end
      cle_pkg::ST_CALL2: state_nxt = cle_pkg::ST_IDLE;
      cle_pkg::ST_POP_RD:
      begin
        if (mem_ack)
          state_nxt = cle_pkg::ST_POP_WB;
      end
      cle_pkg::ST_POP_WB: state_nxt = cle_pkg::ST_IDLE;
      default: state_nxt = cle_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      state_r <= cle_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // call: target and link captured at issue, so a slot write to the source is harmless
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      call_tgt_r <= 32'h0000_0000;
      link_nxt_r <= 32'h0000_0000;
      pr_r <= 32'h0000_0000;
    end
    else
    begin
      if (run && is_call)
      begin
        call_tgt_r <= gpr_rd_data;
        link_nxt_r <= instr_pc + cle_pkg::LINK_OFS;
      end
      if (state_r == cle_pkg::ST_CALL2)
        pr_r <= link_nxt_r;
    end
  end

  // slot tracking: set after the call's second cycle, cleared when the next instruction is taken
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      slot_pend_r <= 1'b0;
      pop_in_slot_r <= 1'b0;
    end
    else
    begin
      if (state_r == cle_pkg::ST_CALL2)
        slot_pend_r <= 1'b1;
      else if (slot_now)
        slot_pend_r <= 1'b0;
      if (run && is_pop)
        pop_in_slot_r <= slot_pend_r;
      else if (pop_done)
        pop_in_slot_r <= 1'b0;
    end
  end

  // memory form of the control load
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pop_addr_r <= 32'h0000_0000;
      pop_data_r <= 32'h0000_0000;
      pop_idx_r <= 4'h0;
      pop_dst_r <= cle_pkg::CR_NONE;
    end
    else
    begin
      if (run && is_pop)
      begin
        pop_addr_r <= gpr_rd_data;
        pop_idx_r <= instr_word[11:8];
        pop_dst_r <= dst;
      end
      if (state_r == cle_pkg::ST_POP_RD && mem_ack)
        pop_data_r <= mem_rdata;
    end
  end

  assign mem_req = state_r == cle_pkg::ST_POP_RD;
  assign mem_addr = pop_addr_r;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      status_r <= 32'h0000_0000;
      gbr_r <= 32'h0000_0000;
      vbr_r <= 32'h0000_0000;
      mod_r <= 32'h0000_0000;
      re_r <= 32'h0000_0000;
      rs_r <= 32'h0000_0000;
    end
    else if (creg_we)
    begin
      case (creg_sel)
        cle_pkg::CR_STATUS: status_r <= creg_data;
        cle_pkg::CR_GBR: gbr_r <= creg_data;
        cle_pkg::CR_VBR: vbr_r <= creg_data;
        cle_pkg::CR_MOD: mod_r <= creg_data;
        cle_pkg::CR_RE: re_r <= creg_data;
        cle_pkg::CR_RS: rs_r <= creg_data;
        default: status_r <= status_r;
      endcase
    end
  end

  // post-increment write-back and pc side outputs, one cycle after the cause
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      gpr_wr_en_r <= 1'b0;
      gpr_wr_idx_r <= 4'h0;
      gpr_wr_data_r <= 32'h0000_0000;
      pc_load_r <= 1'b0;
      pc_target_r <= 32'h0000_0000;
      pc_step_r <= 1'b0;
      illegal_r <= 1'b0;
    end
    else
    begin
      gpr_wr_en_r <= pop_done;
      gpr_wr_idx_r <= pop_idx_r;
      gpr_wr_data_r <= pop_addr_r + cle_pkg::POP_STEP;
      pc_load_r <= slot_end;
      pc_target_r <= call_tgt_r;
      pc_step_r <= step_go;
      illegal_r <= slot_bad;
    end
  end

  // hold off interrupts after a control load until the next instruction issues
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      int_hold_r <= 1'b0;
    else if (ldc_go || pop_done)
      int_hold_r <= 1'b1;
    else if (accept)
      int_hold_r <= 1'b0;
  end

  wire call_window = (state_r == cle_pkg::ST_CALL2) || slot_pend_r;
  assign irq_block = int_hold_r || call_window || (state_r != cle_pkg::ST_IDLE);
  assign addr_err_block = call_window;

  assign gpr_wr_en = gpr_wr_en_r;
  assign gpr_wr_idx = gpr_wr_idx_r;
  assign gpr_wr_data = gpr_wr_data_r;
  assign pc_load = pc_load_r;
  assign pc_target = pc_target_r;
  assign pc_step = pc_step_r;
  assign illegal_slot = illegal_r;
  assign t_flag = status_r[0];
  assign status_reg = status_r;
  assign global_base_register = gbr_r;
  assign vector_base_register = vbr_r;
  assign circular_addressing_register = mod_r;
  assign loop_last_pointer = re_r;
  assign loop_begin_pointer = rs_r;
  assign return_link_holder = pr_r;

  // apb slave: zero wait states, unmapped offsets answer with pslverr
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire hit_ctrl = paddr == cle_pkg::OFS_CTRL;
  wire hit_evt = paddr == cle_pkg::OFS_EVT;
  wire hit_mask = paddr == cle_pkg::OFS_MASK;
  wire hit_state = paddr == cle_pkg::OFS_STATE;
  wire hit_link = paddr == cle_pkg::OFS_LINK;
  wire hit_ll = paddr == cle_pkg::OFS_LOOPLAST;
  wire mapped = hit_ctrl || hit_evt || hit_mask || hit_state || hit_link || hit_ll;
  wire [cle_pkg::EVT_W-1:0] evt_set = {pop_done, state_r == cle_pkg::ST_CALL2, slot_bad};
  wire [cle_pkg::EVT_W-1:0] evt_clr = (apb_wr && hit_evt) ? pwdata[cle_pkg::EVT_W-1:0] : 3'h0;
  // a new event beats a write-one-clear in the same cycle
  wire [cle_pkg::EVT_W-1:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;
  wire [31:0] state_word = {24'h00_0000, int_hold_r, pop_in_slot_r, slot_pend_r, state_r == cle_pkg::ST_POP_WB,
                            state_r == cle_pkg::ST_POP_RD, state_r == cle_pkg::ST_CALL2, t_flag, ctrl_en_r};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, ctrl_en_r}
                     : hit_evt ? {29'h0000_0000, evt_r}
                     : hit_mask ? {29'h0000_0000, mask_r}
                     : hit_state ? state_word
                     : hit_link ? pr_r
                     : hit_ll ? re_r
                     : 32'h0000_0000;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl_en_r <= cle_pkg::CTRL_RESET;
      mask_r <= cle_pkg::MASK_RESET;
      evt_r <= 3'h0;
    end
    else
    begin
      if (apb_wr && hit_ctrl)
        ctrl_en_r <= pwdata[0];
      if (apb_wr && hit_mask)
        mask_r <= pwdata[cle_pkg::EVT_W-1:0];
      evt_r <= evt_nxt;
    end
  end

  // read data registered in the setup cycle so it is stable in the access phase
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= !mapped;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r && apb_acc;
  assign pready = 1'b1;
  assign irq = |(evt_r & mask_r);

endmodule

// >>> rtl/cle_pkg.sv
// shared constants for the call / control-load execution unit
package cle_pkg;
  localparam int DATA_W = 32;
  localparam int APB_AW = 8;
  // instruction patterns and masks
  localparam logic [15:0] CALL_PAT = 16'h400b;
  localparam logic [15:0] CALL_MASK = 16'hf0ff;
  localparam logic [15:0] SLL_PAT = 16'h8e00;
  localparam logic [15:0] SLL_MASK = 16'hff00;
  localparam logic [3:0] GRP_HI = 4'h4;
  localparam logic [3:0] LDC_LO = 4'he;
  localparam logic [3:0] POP_LO = 4'h7;
  // bits 7:4 of the control-load forms
  localparam logic [3:0] SEL_STATUS = 4'h0;
  localparam logic [3:0] SEL_GBR = 4'h1;
  localparam logic [3:0] SEL_VBR = 4'h2;
  localparam logic [3:0] SEL_MOD = 4'h5;
  localparam logic [3:0] SEL_RS = 4'h6;
  localparam logic [3:0] SEL_RE = 4'h7;
  localparam logic [31:0] STATUS_MASK = 32'h0fff0fff;
  localparam logic [31:0] LINK_OFS = 32'h0000_0004;
  localparam logic [31:0] PC_OFS = 32'h0000_0004;
  localparam logic [31:0] SLOT_OFS = 32'h0000_0002;
  localparam logic [31:0] POP_STEP = 32'h0000_0004;
  localparam logic [31:0] INSN_STEP = 32'h0000_0002;
  // register file over apb
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EVT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_LINK = 8'h10;
  localparam logic [7:0] OFS_LOOPLAST = 8'h14;
  localparam int EVT_W = 3;
  localparam int EVT_ILLEGAL = 0;
  localparam int EVT_CALL = 1;
  localparam int EVT_POP = 2;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [2:0] MASK_RESET = 3'h0;
  typedef enum logic [2:0] {
    CR_STATUS,
    CR_GBR,
    CR_VBR,
    CR_MOD,
    CR_RE,
    CR_RS,
    CR_NONE
  } cle_creg_t;
  typedef enum {
    ST_IDLE,
    ST_CALL2,
    ST_POP_RD,
    ST_POP_WB
  } cle_state_t;
endpackage

// >>> verif/call_ctrl_load_exec_tb_top.sv
// self-checking bench for the execution unit
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
module call_ctrl_load_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, instr_is_branch = 1'b0, ext_slot = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mem_ack, er;
  logic [15:0] instr_word = 16'h0000;
  logic [31:0] instr_pc = 32'h0, ext_slot_dest = 32'h0, pwdata = 32'h0, gpr_rd_data, mem_rdata, prdata;
  logic [31:0] mem_addr, gpr_wr_data, pc_target, status_reg, global_base_register, vector_base_register;
  logic [31:0] circular_addressing_register, loop_last_pointer, loop_begin_pointer, return_link_holder;
  logic [31:0] pc, v, tgt, rd, x;
  logic [7:0] paddr = 8'h00, d;
  logic [3:0] gpr_rd_idx, gpr_wr_idx, m;
  logic [1:0] wait_cyc = 2'h0;
  logic instr_ready, gpr_wr_en, mem_req, pc_load, pc_step, illegal_slot, irq_block, addr_err_block, t_flag;
  logic pready, pslverr, irq;
  logic [31:0] gpr [16];
  logic [3:0] sels [6] = '{cle_pkg::SEL_STATUS, cle_pkg::SEL_GBR, cle_pkg::SEL_VBR, cle_pkg::SEL_MOD,
    cle_pkg::SEL_RS, cle_pkg::SEL_RE};
  int mismatches = 0, n_compared = 0, cyc = 0;
  cle_exec_unit u_cle_exec_unit (.*);
  cle_mem_model u_cle_mem_model (.*);
  assign gpr_rd_data = gpr[gpr_rd_idx];
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (gpr_wr_en === 1'b1)
      gpr[gpr_wr_idx] <= gpr_wr_data;
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [31:0] dsp(input logic [7:0] b);
    return {{23{b[7]}}, b, 1'b0};
  endfunction
  function automatic logic [31:0] creg(input logic [3:0] s);
    case (s)
      cle_pkg::SEL_STATUS: return status_reg;
      cle_pkg::SEL_VBR: return vector_base_register;
      cle_pkg::SEL_MOD: return circular_addressing_register;
      cle_pkg::SEL_RS: return loop_begin_pointer;
      cle_pkg::SEL_RE: return loop_last_pointer;
      default: return global_base_register;
    endcase
  endfunction
  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // returns at the falling edge after the instruction was taken
  task automatic issue(input logic [15:0] w, input logic [31:0] a, input logic br, input logic xs);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_pc <= a;
    instr_is_branch <= br;
    ext_slot <= xs;
    wait_cyc <= 2'($urandom_range(3));
    do @(negedge mclk); while (instr_ready !== 1'b1);
    @(posedge mclk);
    instr_valid <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // answer and read data are taken at the rising edge that sees pready
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk);
  endtask
  // pulses are watched live; a copied argument would never change
  task automatic wait_for(input bit pc_side);
    for (int i = 0; i < 20; i++)
    begin
      if (pc_side ? ((pc_load | illegal_slot) === 1'b1) : (gpr_wr_en === 1'b1))
        break;
      @(negedge mclk);
    end
  endtask
  initial
  begin
    x = $urandom(32'hbbf91ba4);
    foreach (gpr[i])
      gpr[i] = $urandom();
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    `CHK("ready", 1'b1, instr_ready)
    apb(1'b0, cle_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'b0, cle_pkg::OFS_MASK, 32'h0);
    `CHK("mask", 32'h0, rd)
    foreach (sels[k])
    begin
      m = 4'($urandom_range(15));
      issue({cle_pkg::GRP_HI, m, sels[k], cle_pkg::LDC_LO}, 32'h100, 1'b0, 1'b0);
      `CHK("ldc", gpr[m], creg(sels[k]))
      `CHK("step", 1'b1, pc_step)
      `CHK("hold", 1'b1, irq_block)
    end
    for (int k = 0; k < 12; k++)
    begin
      m = 4'($urandom_range(15));
      v = gpr[m];
      issue({cle_pkg::GRP_HI, m, sels[k % 6], cle_pkg::POP_LO}, 32'h200, 1'b0, 1'b0);
      wait_for(1'b0);
      @(negedge mclk);
      x = {v[15:0], ~v[15:0]} & ((k % 6 == 0) ? cle_pkg::STATUS_MASK : 32'hffffffff);
      `CHK("pop", x, creg(sels[k % 6]))
      `CHK("inc", v + 32'h4, gpr[m])
      if (k % 6 == 0)
        `CHK("tflag", x[0], t_flag)
    end
    // any displacement is accepted; loop placement stays with software
    for (int k = 0; k < 8; k++)
    begin
      d = (k < 4) ? {k[1], {7{k[0]}}} : 8'($urandom());
      pc = $urandom() & 32'hfffffffe;
      @(posedge mclk);
      ext_slot_dest <= $urandom() & 32'hfffffffe;
      issue({8'h8e, d}, pc, 1'b0, k[0]);
      x = k[0] ? ext_slot_dest + 32'h2 : pc + 32'h4;
      `CHK("llp", x + dsp(d), loop_last_pointer)
      `CHK("sstep", 1'b1, pc_step)
    end
    for (int kd = 0; kd < 3; kd++)
    begin
      m = 4'($urandom_range(15));
      tgt = gpr[m];
      pc = $urandom() & 32'hfffffffe;
      d = 8'($urandom());
      issue({cle_pkg::GRP_HI, m, 8'h0b}, pc, 1'b1, 1'b0);
      @(negedge mclk);
      `CHK("link", pc + 32'h4, return_link_holder)
      v = (kd == 1) ? {cle_pkg::GRP_HI, m, cle_pkg::SEL_RE, cle_pkg::POP_LO} : {8'h8e, d};
      issue(kd == 2 ? {4'h4, m, 8'h2b} : v[15:0], pc + 32'h2, kd == 2, 1'b0);
      wait_for(1'b1);
      `CHK("load", kd != 2, pc_load)
      `CHK("ill", kd == 2, illegal_slot)
      if (kd != 2)
        `CHK("tgt", tgt, pc_target)
      if (kd == 0)
        `CHK("slot", tgt + 32'h2 + dsp(d), loop_last_pointer)
      repeat (4) @(negedge mclk);
    end
    apb(1'b0, cle_pkg::OFS_EVT, 32'h0);
    `CHK("evt", 32'h7, rd)
    apb(1'b1, cle_pkg::OFS_EVT, 32'h5);
    apb(1'b1, cle_pkg::OFS_MASK, 32'h5);
    `CHK("masked", 1'b0, irq)
    apb(1'b1, cle_pkg::OFS_MASK, 32'h2);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, cle_pkg::OFS_EVT, 32'h2);
    `CHK("clr", 1'b0, irq)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("err", 1'b1, er)
    apb(1'b1, cle_pkg::OFS_CTRL, 32'h0);
    `CHK("off", 1'b0, instr_ready)
    apb(1'b1, cle_pkg::OFS_CTRL, 32'h1);
    complete_run();
  end
endmodule

// >>> verif/cle_exec_unit_properties.sv
// port-level assertions for the execution unit
module cle_exec_unit_properties (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic instr_is_branch,
  input wire logic ext_slot,
  input wire logic [31:0] gpr_rd_data,
  input wire logic gpr_wr_en,
  input wire logic [31:0] gpr_wr_data,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic pc_load,
  input wire logic [31:0] pc_target,
  input wire logic pc_step,
  input wire logic illegal_slot,
  input wire logic irq_block,
  input wire logic addr_err_block,
  input wire logic [31:0] return_link_holder,
  input wire logic [31:0] loop_last_pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [31:0] tgt_r;
  wire take = instr_valid && instr_ready;
  wire grp = instr_word[15:12] == cle_pkg::GRP_HI;
  // a call offered in a slot is refused as illegal, so it is not a call here
  wire call_w = take && !addr_err_block && ((instr_word & cle_pkg::CALL_MASK) == cle_pkg::CALL_PAT);
  wire ldc_w = take && grp && instr_word[3:0] == cle_pkg::LDC_LO;
  wire pop_w = take && grp && instr_word[3:0] == cle_pkg::POP_LO;
  wire sll_w = take && ((instr_word & cle_pkg::SLL_MASK) == cle_pkg::SLL_PAT);
  wire slot_w = take && addr_err_block;
  function automatic logic [31:0] dsp(input logic [7:0] d);
    return {{23{d[7]}}, d, 1'b0};
  endfunction
  // target kept from the call edge, so a slot rewrite of the register does not change it
  always_ff @(posedge mclk)
  begin
    if (call_w)
      tgt_r <= gpr_rd_data;
  end
  AST_CALL_TWO: assert property (call_w |=> !instr_ready ##1 instr_ready)
    else $error("call did not take two cycles");
  AST_CALL_HOLD: assert property (call_w |=> addr_err_block [*2])
    else $error("exceptions not held after call");
  AST_CALL_LINK: assert property (call_w |-> ##2 return_link_holder == $past(instr_pc, 2) + cle_pkg::LINK_OFS)
    else $error("wrong return link");
  AST_SLOT_TGT: assert property (pc_load |-> pc_target == tgt_r)
    else $error("wrong call target");
  AST_SLOT_ILL: assert property (slot_w && instr_is_branch |=> illegal_slot && !pc_load)
    else $error("branch in slot not flagged");
  AST_SLOT_RUN: assert property (slot_w && sll_w && !instr_is_branch |=>
    pc_load && !pc_step && loop_last_pointer == tgt_r + cle_pkg::SLOT_OFS + dsp($past(instr_word[7:0])))
    else $error("slot load wrong");
  AST_SLL: assert property (sll_w && !addr_err_block && !ext_slot |=> pc_step &&
    loop_last_pointer == $past(instr_pc) + cle_pkg::PC_OFS + dsp($past(instr_word[7:0])))
    else $error("loop last value wrong");
  AST_LDC: assert property (ldc_w && !addr_err_block |=> pc_step && irq_block)
    else $error("register load step or hold wrong");
  AST_POP_ISSUE: assert property (pop_w |=> mem_req && mem_addr == $past(gpr_rd_data))
    else $error("pop read address wrong");
  AST_POP_WAIT: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("read dropped before answer");
  AST_POP_WB: assert property (mem_req && mem_ack |-> ##2 gpr_wr_en &&
    gpr_wr_data == $past(mem_addr, 2) + cle_pkg::POP_STEP)
    else $error("post increment wrong");
  cover property (call_w);
  cover property (illegal_slot);
  cover property (gpr_wr_en);
  cover property (sll_w && ext_slot);
endmodule
bind cle_exec_unit cle_exec_unit_properties u_props (.mclk, .reset_n, .instr_valid, .instr_ready, .instr_word,
  .instr_pc, .instr_is_branch, .ext_slot, .gpr_rd_data, .gpr_wr_en, .gpr_wr_data, .mem_req, .mem_addr, .mem_ack,
  .pc_load, .pc_target, .pc_step, .illegal_slot, .irq_block, .addr_err_block, .return_link_holder,
  .loop_last_pointer);

// >>> verif/cle_mem_model.sv
// data-bus model answering long-word reads after a chosen number of wait cycles
module cle_mem_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] wait_cyc,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !mem_req)
      cnt_r <= wait_cyc;
    else if (cnt_r != 2'h0)
      cnt_r <= cnt_r - 2'h1;
  end
  // zero wait answers within the first request cycle
  assign mem_ack = mem_req && cnt_r == 2'h0;
  // outside the answer cycle the word is inverted so a stale capture shows
  assign mem_rdata = {mem_addr[15:0], ~mem_addr[15:0]} ^ {32{!mem_ack}};
endmodule
